// ---- logic/bstp_pkg.sv ----
// Shared constants and types for the boundary-scan test port
package bstp_pkg;

    // Instruction register
    localparam int          IR_WIDTH        = 4;
    localparam logic [3:0]  IR_RESET_VALUE  = 4'h1;
    localparam logic [3:0]  IR_CAPTURE_VAL  = 4'h1;

    // Instruction codes
    localparam logic [3:0]  INSTR_EXTEST    = 4'h0;
    localparam logic [3:0]  INSTR_IDCODE    = 4'h2;
    localparam logic [3:0]  INSTR_BYPASS    = 4'hF;

    // Identification register (value arbitrary, names no maker)
    localparam int          ID_WIDTH        = 32;
    localparam logic [31:0] ID_VALUE        = 32'h1234_5001;

    // Bypass register
    localparam logic        BYPASS_CAPTURE  = 1'h0;

    // Synchroniser depth on pin inputs
    localparam int          SYNC_STAGES     = 2;

    // Test access port controller states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR_SCAN,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR_SCAN,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } bstp_state_type;

endpackage

// ---- logic/bstp_sync.sv ----
// Two-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module bstp_sync (
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    input  wire logic clk_en_i,
    input  wire logic pin_i,
    output logic      sync_o
);
    logic meta;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta   <= 1'h0;
            sync_o <= 1'h0;
        end else if (clk_en_i) begin
            meta   <= pin_i;
            sync_o <= meta;
        end
    end
endmodule
`default_nettype wire

// ---- logic/bstp_top.sv ----
// Boundary-scan test access port: controller, IR, ID and bypass paths
// Notes on behaviour
// - Test reset forces controller reset, no clock.
// - Mode select sampled on test-clock rise.
// - Test data captured on rise while shifting.
// - Shift feeds instruction, ID or bypass.
// - Test data out changes on clock fall.
// - Output enabled only in shift states.
`timescale 1ns/1ps
`default_nettype none
module bstp_top (
    input  wire logic  ref_clk_i,
    input  wire logic  reset_n_i,
    input  wire logic  clk_en_i,
    input  wire logic  tck_i,
    input  wire logic  tms_i,
    input  wire logic  tdi_i,
    input  wire logic  trst_n_i,
    output logic       tdo_o,
    output logic       tdo_oe_o,
    output logic [3:0] instr_o
);
    logic                   tck_s;
    logic                   tms_s;
    logic                   tdi_s;
    logic                   tck_d;
    logic                   tck_rise;
    logic                   tck_fall;
    logic                   trst_n_s;
    logic                   trst_sync;
    logic                   tap_rst_n;
    bstp_pkg::bstp_state_type state;
    bstp_pkg::bstp_state_type next_state;
    logic [3:0]             ir_shift;
    logic [3:0]             ir;
    logic [31:0]            id_shift;
    logic                   bypass;
    logic                   serial_out;

    bstp_sync u_sync_tck (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i), .pin_i(tck_i), .sync_o(tck_s));
    bstp_sync u_sync_tms (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i), .pin_i(tms_i), .sync_o(tms_s));
    bstp_sync u_sync_tdi (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i), .pin_i(tdi_i), .sync_o(tdi_s));
    bstp_sync u_sync_trst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i), .pin_i(trst_n_i), .sync_o(trst_sync));

    // Test reset acts asynchronously; only its release is synchronised
    assign tap_rst_n = reset_n_i & trst_n_i;
    assign trst_n_s  = trst_sync;

    always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tck_d <= 1'h0;
        end else if (clk_en_i) begin
            tck_d <= tck_s;
        end
    end

    // Edges only count once the synchronised reset has released too
    assign tck_rise = clk_en_i & trst_n_s & tck_s & ~tck_d;
    assign tck_fall = clk_en_i & trst_n_s & ~tck_s & tck_d;

    function automatic logic in_shift(input bstp_pkg::bstp_state_type s);
        in_shift = (s == bstp_pkg::SHIFT_DR) || (s == bstp_pkg::SHIFT_IR);
    endfunction

    always_comb begin
        next_state = state;
        case (state)
            bstp_pkg::TEST_LOGIC_RESET: next_state = tms_s ?
                bstp_pkg::TEST_LOGIC_RESET : bstp_pkg::RUN_TEST_IDLE;
            bstp_pkg::RUN_TEST_IDLE: next_state = tms_s ?
                bstp_pkg::SELECT_DR_SCAN : bstp_pkg::RUN_TEST_IDLE;
            bstp_pkg::SELECT_DR_SCAN: next_state = tms_s ?
                bstp_pkg::SELECT_IR_SCAN : bstp_pkg::CAPTURE_DR;
            bstp_pkg::CAPTURE_DR: next_state = tms_s ?
                bstp_pkg::EXIT1_DR : bstp_pkg::SHIFT_DR;
            bstp_pkg::SHIFT_DR: next_state = tms_s ?
                bstp_pkg::EXIT1_DR : bstp_pkg::SHIFT_DR;
            bstp_pkg::EXIT1_DR: next_state = tms_s ?
                bstp_pkg::UPDATE_DR : bstp_pkg::PAUSE_DR;
            bstp_pkg::PAUSE_DR: next_state = tms_s ?
                bstp_pkg::EXIT2_DR : bstp_pkg::PAUSE_DR;
            bstp_pkg::EXIT2_DR: next_state = tms_s ?
                bstp_pkg::UPDATE_DR : bstp_pkg::SHIFT_DR;
            bstp_pkg::UPDATE_DR: next_state = tms_s ?
                bstp_pkg::SELECT_DR_SCAN : bstp_pkg::RUN_TEST_IDLE;
            bstp_pkg::SELECT_IR_SCAN: next_state = tms_s ?
                bstp_pkg::TEST_LOGIC_RESET : bstp_pkg::CAPTURE_IR;
            bstp_pkg::CAPTURE_IR: next_state = tms_s ?
                bstp_pkg::EXIT1_IR : bstp_pkg::SHIFT_IR;
            bstp_pkg::SHIFT_IR: next_state = tms_s ?
                bstp_pkg::EXIT1_IR : bstp_pkg::SHIFT_IR;
            bstp_pkg::EXIT1_IR: next_state = tms_s ?
                bstp_pkg::UPDATE_IR : bstp_pkg::PAUSE_IR;
            bstp_pkg::PAUSE_IR: next_state = tms_s ?
                bstp_pkg::EXIT2_IR : bstp_pkg::PAUSE_IR;
            bstp_pkg::EXIT2_IR: next_state = tms_s ?
                bstp_pkg::UPDATE_IR : bstp_pkg::SHIFT_IR;
            bstp_pkg::UPDATE_IR: next_state = tms_s ?
                bstp_pkg::SELECT_DR_SCAN : bstp_pkg::RUN_TEST_IDLE;
            default: next_state = bstp_pkg::TEST_LOGIC_RESET;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state <= bstp_pkg::TEST_LOGIC_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // Instruction shift and update
    always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_shift <= bstp_pkg::IR_RESET_VALUE;
            ir       <= bstp_pkg::IR_RESET_VALUE;
        end else if (tck_rise) begin
            case (state)
                bstp_pkg::TEST_LOGIC_RESET:
                    ir <= bstp_pkg::IR_RESET_VALUE;
                bstp_pkg::CAPTURE_IR:
                    ir_shift <= bstp_pkg::IR_CAPTURE_VAL;
                bstp_pkg::SHIFT_IR:
                    ir_shift <= {tdi_s, ir_shift[3:1]};
                bstp_pkg::UPDATE_IR:
                    ir <= ir_shift;
                default: ir <= ir;
            endcase
        end
    end

    // Data registers: identification or bypass by current instruction
    always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            id_shift <= bstp_pkg::ID_VALUE;
            bypass   <= bstp_pkg::BYPASS_CAPTURE;
        end else if (tck_rise) begin
            if (state == bstp_pkg::CAPTURE_DR) begin
                id_shift <= bstp_pkg::ID_VALUE;
                bypass   <= bstp_pkg::BYPASS_CAPTURE;
            end else if (state == bstp_pkg::SHIFT_DR) begin
                if (ir == bstp_pkg::INSTR_IDCODE) begin
                    id_shift <= {tdi_s, id_shift[31:1]};
                end else begin
                    bypass <= tdi_s;
                end
            end
        end
    end

    always_comb begin
        if (state == bstp_pkg::SHIFT_IR) begin
            serial_out = ir_shift[0];
        end else if (ir == bstp_pkg::INSTR_IDCODE) begin
            serial_out = id_shift[0];
        end else begin
            serial_out = bypass;
        end
    end

    // Output launches on falling edge, enabled only while shifting
    always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo_o    <= 1'h0;
            tdo_oe_o <= 1'h0;
        end else if (tck_fall) begin
            tdo_o    <= serial_out;
            tdo_oe_o <= in_shift(state);
        end
    end

    assign instr_o = ir;

    property p_oe_shift;
        @(posedge ref_clk_i) disable iff (!tap_rst_n)
        $rose(tdo_oe_o) |-> in_shift(state);
    endproperty
    a_oe_shift: assert property (p_oe_shift)
        else $error("Output enabled outside shift state");

    property p_tdo_fall;
        @(posedge ref_clk_i) disable iff (!tap_rst_n)
        $changed(tdo_o) |-> $past(tck_fall);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall)
        else $error("Test data out changed off falling edge");

    property p_state_rise;
        @(posedge ref_clk_i) disable iff (!tap_rst_n)
        $changed(state) |-> $past(tck_rise);
    endproperty
    a_state_rise: assert property (p_state_rise)
        else $error("Controller moved without rising edge");

    property p_tms_reset;
        @(posedge ref_clk_i) disable iff (!tap_rst_n)
        (tck_rise && tms_s && state == bstp_pkg::SELECT_IR_SCAN)
            |=> state == bstp_pkg::TEST_LOGIC_RESET;
    endproperty
    a_tms_reset: assert property (p_tms_reset)
        else $error("Select-IR with mode high did not reset");

    property p_bypass_cap;
        @(posedge ref_clk_i) disable iff (!tap_rst_n)
        (tck_rise && state == bstp_pkg::SHIFT_DR
            && ir == bstp_pkg::INSTR_BYPASS) |=> bypass == $past(tdi_s);
    endproperty
    a_bypass_cap: assert property (p_bypass_cap)
        else $error("Bypass stage did not take test data");

    property p_ir_shift;
        @(posedge ref_clk_i) disable iff (!tap_rst_n)
        (tck_rise && state == bstp_pkg::SHIFT_IR)
            |=> ir_shift[3] == $past(tdi_s);
    endproperty
    a_ir_shift: assert property (p_ir_shift)
        else $error("Instruction path did not take test data");

    property p_trst;
        @(posedge ref_clk_i) !trst_n_i |-> state == bstp_pkg::TEST_LOGIC_RESET;
    endproperty
    a_trst: assert property (p_trst)
        else $error("Controller not reset under test reset");

    property p_oe_off;
        @(posedge ref_clk_i) !tap_rst_n |-> !tdo_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("Output enabled during reset");

endmodule
`default_nettype wire

// ---- test/bstp_host.sv ----
// Host model: drives the test clock, mode select and data pins
`timescale 1ns/1ps
`default_nettype none
module bstp_host (
    input  wire logic ref_clk_i,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    // Half of the 200 ns test-clock period, in reference cycles
    localparam int HALF = 4;

    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h0;
    end

    // One test-clock period; returns the port as seen before the rise
    task automatic step(input logic tms, input logic tdi,
                        output logic tdo, output logic oe);
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (HALF - 1) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        tdo = tdo_i;
        oe = tdo_oe_i;
        @(posedge ref_clk_i);
        tck_o <= 1'h1;
        repeat (HALF) @(posedge ref_clk_i);
        tck_o <= 1'h0;
    endtask
endmodule
`default_nettype wire

// ---- test/test_bstp_top.sv ----
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module test_bstp_top;
    localparam logic [31:0] PAT = 32'hA5C3_0F96;
    localparam logic [31:0] BYP = {PAT[30:0], bstp_pkg::BYPASS_CAPTURE};
    typedef struct packed {
        logic [3:0]  ir;
        logic [31:0] exp;
    } bstp_row_type;

    logic         ref_clk_i = 1'h0;
    logic         reset_n_i;
    logic         trst_n_i;
    logic         clk_en_i  = 1'h1;
    wire logic    tck;
    wire logic    tms;
    wire logic    tdi;
    logic         tdo_o;
    logic         tdo_oe_o;
    logic [3:0]   instr_o;
    int           n_errors  = 0;
    int           checked   = 0;
    bstp_row_type rows [3]  = '{
        '{bstp_pkg::INSTR_IDCODE, bstp_pkg::ID_VALUE},
        '{bstp_pkg::INSTR_BYPASS, BYP},
        '{bstp_pkg::INSTR_EXTEST, BYP}};

    always #12.5 ref_clk_i = ~ref_clk_i;

    bstp_top dut (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n_i),
        .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .instr_o(instr_o));

    bstp_host host (
        .ref_clk_i(ref_clk_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o),
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic final_report;
        $display("errors %0d checked %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Walks the mode select through n bits, first bit first
    task automatic moves(input logic [7:0] seq, input int n);
        logic t;
        logic oe;
        for (int i = 0; i < n; i++)
            host.step(seq[i], ~seq[i], t, oe);
    endtask

    // From a shift state: n bits through, then exit, update, idle
    task automatic shift(input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        logic t;
        logic oe;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            host.step(i == n - 1, din[i], t, oe);
            dout[i] = t;
            check(32'(oe), 32'h1, "enable while shifting");
        end
        host.step(1'h1, 1'h1, t, oe);
        check(32'(oe), 32'h0, "enable after exit");
        host.step(1'h0, 1'h0, t, oe);
    endtask

    task automatic load_ir(input logic [3:0] code);
        logic [31:0] d;
        moves(8'h03, 4);
        shift(bstp_pkg::IR_WIDTH, 32'(code), d);
        check(d, 32'(bstp_pkg::IR_CAPTURE_VAL), "ir capture");
        check(32'(instr_o), 32'(code), "instruction");
    endtask

    task automatic scan_dr(output logic [31:0] d);
        moves(8'h01, 3);
        shift(32, PAT, d);
    endtask

    initial begin
        logic [31:0] d;
        // Scheduled so the reset edge reaches every process at time 0
        reset_n_i <= 1'h0;
        trst_n_i  <= 1'h0;
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1'h1;
        @(posedge ref_clk_i);
        moves(8'h00, 3);
        check(32'(instr_o), 32'(bstp_pkg::IR_RESET_VALUE), "held");
        check(32'(tdo_oe_o), 32'h0, "enable in reset");
        @(posedge ref_clk_i);
        trst_n_i <= 1'h1;
        repeat (8) @(posedge ref_clk_i);
        moves(8'h00, 1);
        scan_dr(d);
        check(d, BYP, "reset path");
        foreach (rows[k]) begin
            load_ir(rows[k].ir);
            scan_dr(d);
            check(d, rows[k].exp, "data path");
        end
        moves(8'h1F, 5);
        check(32'(instr_o), 32'(bstp_pkg::IR_RESET_VALUE), "tms");
        moves(8'h00, 1);
        load_ir(bstp_pkg::INSTR_IDCODE);
        // Test-clock edges seen while disabled must be lost
        clk_en_i <= 1'h0;
        moves(8'h1F, 5);
        clk_en_i <= 1'h1;
        check(32'(instr_o), 32'(bstp_pkg::INSTR_IDCODE), "frozen");
        moves(8'h01, 3);
        repeat (5) @(posedge ref_clk_i);
        check(32'(tdo_oe_o), 32'h1, "enable in shift");
        trst_n_i <= 1'h0;
        #2;
        check(32'(instr_o), 32'(bstp_pkg::IR_RESET_VALUE), "trst");
        check(32'(tdo_oe_o), 32'h0, "trst enable");
        final_report;
    end

    initial begin
        #200us;
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report;
    end
endmodule
`default_nettype wire
